// ===== logic/uts_port.sv
// Purpose: three-mode serial port with data, control and pending registers
// Assumes: one-cycle strobes, read data valid the cycle after the read strobe
// Notes: receive pin is two-way in shift-register mode
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module uts_port #(
   parameter int DIV_W = 16
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [7:0] rd_data_o,
   input wire logic rx_i,
   output logic rx_o,
   output logic rx_oe_o,
   output logic tx_o,
   output logic irq_o
);
   // ==========================================================
   // declarations
   logic tick;
   logic [7:0] ctrl_q, ctrl_d, pend_q, pend_d, rxbuf_q, rxbuf_d, txbuf_q, txbuf_d;
   logic [7:0] rdata_q, rdata_d;
   logic [15:0] div_q, div_d;
   logic irq_q, irq_d, go_q, go_d;
   uts_pkg::uts_mode_t mode;
   logic rxen, tb8, parity_enable, receive_pending_flag, wr_data, wr_pend, wr_ctrl, nine;
   uts_pkg::uts_tx_st_t tx_st_q, tx_st_d;
   logic [3:0] tx_sub_q, tx_sub_d;
   logic [3:0] tx_cnt_q, tx_cnt_d;
   logic [7:0] tx_sh_q, tx_sh_d;
   logic tx_nin_q, tx_nin_d, dir_q, dir_d, take;
   logic tx_pin_q, tx_pin_d, rxo_q, rxo_d, rxoe_q, rxoe_d;
   logic tx_done, sync_done;
   uts_pkg::uts_rx_st_t rx_st_q, rx_st_d;
   logic [3:0] rx_sub_q, rx_sub_d;
   logic [3:0] rx_cnt_q, rx_cnt_d;
   logic [8:0] rx_sh_q, rx_sh_d;
   logic rx_done;
   logic [7:0] rx_byte;
   logic rx_stop, par_err;

   assign mode = uts_pkg::uts_mode_t'(ctrl_q[uts_pkg::UTS_CTRL_MODE_LSB +: 2]);
   assign nine = mode[1];
   assign rxen = ctrl_q[uts_pkg::UTS_CTRL_RXEN];
   assign tb8 = ctrl_q[uts_pkg::UTS_CTRL_TB8];
   assign parity_enable = pend_q[uts_pkg::UTS_PEND_PEN];
   assign receive_pending_flag = pend_q[uts_pkg::UTS_PEND_RIP];
   assign wr_data = wr_en_i && addr_i == uts_pkg::UTS_DATA_OFS;
   assign wr_pend = wr_en_i && addr_i == uts_pkg::UTS_PEND_OFS;
   assign wr_ctrl = wr_en_i && addr_i == uts_pkg::UTS_CTRL_OFS;

   uts_tick #(
      .DIV_W(16)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .div_i(div_q),
      .tick_o(tick)
   );

   // ==========================================================
   // transmit engine, also runs the shift-register mode both ways
   always_comb begin
      tx_st_d = tx_st_q;
      tx_sub_d = tx_sub_q;
      tx_cnt_d = tx_cnt_q;
      tx_sh_d = tx_sh_q;
      tx_nin_d = tx_nin_q;
      dir_d = dir_q;
      rxo_d = rxo_q;
      rxoe_d = rxoe_q;
      tx_pin_d = tx_pin_q;
      take = 1'b0;
      tx_done = 1'b0;
      sync_done = 1'b0;
      if (tick) begin
         tx_sub_d = tx_sub_q + 4'h1;
      end
      unique case (tx_st_q)
         uts_pkg::UTS_TX_IDLE: begin
            tx_sub_d = 4'h0;
            tx_cnt_d = 4'h0;
            tx_pin_d = 1'b1;
            rxoe_d = 1'b0;
            if (go_q) begin
               take = 1'b1;
               tx_sh_d = txbuf_q;
               // even parity when the control is 0, odd when 1
               tx_nin_d = parity_enable ? (^txbuf_q) ^ tb8 : tb8;
               dir_d = 1'b0;
               if (mode == uts_pkg::UTS_MODE_SHIFT) begin
                  tx_st_d = uts_pkg::UTS_TX_SYNC;
                  rxoe_d = 1'b1;
                  rxo_d = txbuf_q[0];
               end else begin
                  tx_st_d = uts_pkg::UTS_TX_START;
                  tx_pin_d = 1'b0;
               end
            end else if (mode == uts_pkg::UTS_MODE_SHIFT && rxen && !receive_pending_flag) begin
               tx_st_d = uts_pkg::UTS_TX_SYNC;
               dir_d = 1'b1;
            end
         end
         uts_pkg::UTS_TX_SYNC: begin
            // clock low for the first half bit, high for the second
            tx_pin_d = tx_sub_d[3];
            if (tick && tx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               // sample at the end of the high phase, data settled for half a bit
               tx_sh_d = {dir_q ? rx_i : 1'b0, tx_sh_q[7:1]};
               rxo_d = tx_sh_q[1];
               tx_cnt_d = tx_cnt_q + 4'h1;
               if (tx_cnt_q == uts_pkg::UTS_BIT_LAST8) begin
                  tx_st_d = uts_pkg::UTS_TX_IDLE;
                  tx_done = !dir_q;
                  sync_done = dir_q;
                  rxoe_d = 1'b0;
               end
            end
            if (dir_q && !rxen) begin
               tx_st_d = uts_pkg::UTS_TX_IDLE;
            end
         end
         uts_pkg::UTS_TX_START: begin
            if (tick && tx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               tx_st_d = uts_pkg::UTS_TX_DATA;
               tx_pin_d = tx_sh_q[0];
            end
         end
         uts_pkg::UTS_TX_DATA: begin
            if (tick && tx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               tx_sh_d = {1'b0, tx_sh_q[7:1]};
               tx_pin_d = tx_sh_q[1];
               tx_cnt_d = tx_cnt_q + 4'h1;
               if (tx_cnt_q == uts_pkg::UTS_BIT_LAST8) begin
                  if (nine) begin
                     tx_st_d = uts_pkg::UTS_TX_NINTH;
                     tx_pin_d = tx_nin_q;
                  end else begin
                     tx_st_d = uts_pkg::UTS_TX_STOP;
                     tx_pin_d = 1'b1;
                     tx_done = 1'b1;
                  end
               end
            end
         end
         uts_pkg::UTS_TX_NINTH: begin
            if (tick && tx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               tx_st_d = uts_pkg::UTS_TX_STOP;
               tx_pin_d = 1'b1;
               tx_done = 1'b1;
            end
         end
         uts_pkg::UTS_TX_STOP: begin
            if (tick && tx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               tx_st_d = uts_pkg::UTS_TX_IDLE;
            end
         end
         default: begin
            tx_st_d = uts_pkg::UTS_TX_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tx_st_q <= uts_pkg::UTS_TX_IDLE;
         tx_sub_q <= 4'h0;
         tx_cnt_q <= 4'h0;
         tx_sh_q <= uts_pkg::UTS_BYTE_RST;
         tx_nin_q <= 1'b0;
         dir_q <= 1'b0;
         rxo_q <= 1'b0;
         rxoe_q <= 1'b0;
         tx_pin_q <= 1'b1;
      end else begin
         tx_st_q <= tx_st_d;
         tx_sub_q <= tx_sub_d;
         tx_cnt_q <= tx_cnt_d;
         tx_sh_q <= tx_sh_d;
         tx_nin_q <= tx_nin_d;
         dir_q <= dir_d;
         rxo_q <= rxo_d;
         rxoe_q <= rxoe_d;
         tx_pin_q <= tx_pin_d;
      end
   end

   // ==========================================================
   // asynchronous receiver
   always_comb begin
      rx_st_d = rx_st_q;
      rx_sub_d = rx_sub_q;
      rx_cnt_d = rx_cnt_q;
      rx_sh_d = rx_sh_q;
      rx_done = 1'b0;
      if (tick) begin
         rx_sub_d = rx_sub_q + 4'h1;
      end
      unique case (rx_st_q)
         uts_pkg::UTS_RX_IDLE: begin
            rx_sub_d = 4'h0;
            rx_cnt_d = 4'h0;
            if (tick && rxen && mode != uts_pkg::UTS_MODE_SHIFT && !rx_i) begin
               rx_st_d = uts_pkg::UTS_RX_START;
            end
         end
         uts_pkg::UTS_RX_START: begin
            if (tick && rx_sub_q == uts_pkg::UTS_TICK_MID) begin
               // a glitch shorter than half a bit is not a start bit
               rx_st_d = rx_i ? uts_pkg::UTS_RX_IDLE : uts_pkg::UTS_RX_DATA;
               rx_sub_d = 4'h0;
            end
         end
         uts_pkg::UTS_RX_DATA: begin
            if (tick && rx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               rx_sh_d = {rx_i, rx_sh_q[8:1]};
               rx_cnt_d = rx_cnt_q + 4'h1;
               if (rx_cnt_q == (nine ? uts_pkg::UTS_BIT_LAST9 : uts_pkg::UTS_BIT_LAST8)) begin
                  rx_st_d = uts_pkg::UTS_RX_STOP;
               end
            end
         end
         uts_pkg::UTS_RX_STOP: begin
            if (tick && rx_sub_q == uts_pkg::UTS_TICK_LAST) begin
               rx_st_d = uts_pkg::UTS_RX_IDLE;
               rx_done = 1'b1;
            end
         end
      endcase
      if (!rxen) begin
         rx_st_d = uts_pkg::UTS_RX_IDLE;
         rx_done = 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rx_st_q <= uts_pkg::UTS_RX_IDLE;
         rx_sub_q <= 4'h0;
         rx_cnt_q <= 4'h0;
         rx_sh_q <= 9'h000;
      end else begin
         rx_st_q <= rx_st_d;
         rx_sub_q <= rx_sub_d;
         rx_cnt_q <= rx_cnt_d;
         rx_sh_q <= rx_sh_d;
      end
   end

   // eight-bit frames leave the data one place higher in the shifter
   assign rx_byte = nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
   assign rx_stop = rx_i;
   // error when the ninth bit disagrees with the selected parity
   assign par_err = rx_sh_q[8] != ((^rx_sh_q[7:0]) ^ ctrl_q[uts_pkg::UTS_CTRL_RB8]);

   // ==========================================================
   // register file
   always_comb begin
      ctrl_d = ctrl_q;
      pend_d = pend_q;
      rxbuf_d = rxbuf_q;
      txbuf_d = txbuf_q;
      div_d = div_q;
      go_d = go_q && !take;
      rdata_d = 8'h00;
      if (wr_ctrl) begin
         ctrl_d = wr_data_i;
      end
      if (wr_pend) begin
         // software writes bits 5, 3, 1 and 0 as given, others cleared; a same-cycle hardware set wins below
         pend_d = wr_data_i & 8'h2b;
      end
      if (wr_data) begin
         txbuf_d = wr_data_i;
         go_d = 1'b1;
      end
      if (wr_en_i && addr_i == uts_pkg::UTS_DIVL_OFS) begin
         div_d[7:0] = wr_data_i;
      end
      if (wr_en_i && addr_i == uts_pkg::UTS_DIVH_OFS) begin
         div_d[15:8] = wr_data_i;
      end
      if (tx_done) begin
         pend_d[uts_pkg::UTS_PEND_TIP] = 1'b1;
      end
      if (sync_done) begin
         rxbuf_d = tx_sh_d;
         pend_d[uts_pkg::UTS_PEND_RIP] = 1'b1;
      end
      if (rx_done) begin
         // an unread byte is simply overwritten
         rxbuf_d = rx_byte;
         pend_d[uts_pkg::UTS_PEND_RIP] = 1'b1;
         if (!nine) begin
            ctrl_d[uts_pkg::UTS_CTRL_RB8] = rx_stop;
         end else if (!parity_enable) begin
            ctrl_d[uts_pkg::UTS_CTRL_RB8] = rx_sh_q[8];
         end else begin
            pend_d[uts_pkg::UTS_PEND_RPE] = par_err;
         end
      end
      if (rd_en_i) begin
         unique case (addr_i)
            uts_pkg::UTS_PEND_OFS: rdata_d = pend_q;
            uts_pkg::UTS_DATA_OFS: rdata_d = rxbuf_q;
            uts_pkg::UTS_CTRL_OFS: rdata_d = ctrl_q;
            uts_pkg::UTS_DIVL_OFS: rdata_d = div_q[7:0];
            uts_pkg::UTS_DIVH_OFS: rdata_d = div_q[15:8];
            default: rdata_d = 8'h00;
         endcase
      end
      irq_d = (pend_d[uts_pkg::UTS_PEND_TIP] && ctrl_d[uts_pkg::UTS_CTRL_TIE]) ||
              (pend_d[uts_pkg::UTS_PEND_RIP] && ctrl_d[uts_pkg::UTS_CTRL_RIE]);
   end
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ctrl_q <= uts_pkg::UTS_CTRL_RST;
         pend_q <= uts_pkg::UTS_PEND_RST;
         rxbuf_q <= uts_pkg::UTS_BYTE_RST;
         txbuf_q <= uts_pkg::UTS_BYTE_RST;
         div_q <= uts_pkg::UTS_DIV_RST;
         go_q <= 1'b0;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         pend_q <= pend_d;
         rxbuf_q <= rxbuf_d;
         txbuf_q <= txbuf_d;
         div_q <= div_d;
         go_q <= go_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
      end
   end

   assign rd_data_o = rdata_q;
   assign rx_o = rxo_q;
   assign rx_oe_o = rxoe_q;
   assign tx_o = tx_pin_q;
   assign irq_o = irq_q;

   // ==========================================================
   // checks
   a_tip_set: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      tx_done |=> pend_q[uts_pkg::UTS_PEND_TIP])
      else $error("transmit pending not set");
   a_rip_kept: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      pend_q[uts_pkg::UTS_PEND_RIP] && !wr_pend |=> pend_q[uts_pkg::UTS_PEND_RIP])
      else $error("receive pending cleared by hardware");
   a_stop_high: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      tx_st_q == uts_pkg::UTS_TX_STOP |-> tx_pin_q)
      else $error("stop bit not high");
   a_start_low: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      tx_st_q == uts_pkg::UTS_TX_START |-> !tx_pin_q)
      else $error("start bit not low");
   a_data_starts: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      wr_data && tx_st_q == uts_pkg::UTS_TX_IDLE && !go_q |=> ##1 tx_st_q != uts_pkg::UTS_TX_IDLE)
      else $error("data write did not start transmission");
   a_rx_abandon: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !rxen && !$past(rxen) |-> rx_st_q == uts_pkg::UTS_RX_IDLE)
      else $error("reception kept running while disabled");
   a_rip_pulse: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      rx_done |=> pend_q[uts_pkg::UTS_PEND_RIP] && rxbuf_q == $past(rx_byte))
      else $error("received byte not stored");
   a_ctrl_reset: assert property (@(posedge clk_sys_i)
      $past(sys_rst_i) |-> ctrl_q == uts_pkg::UTS_CTRL_RST)
      else $error("control not cleared by reset");
   a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      irq_o |-> (pend_q[0] && ctrl_q[0]) || (pend_q[1] && ctrl_q[1]))
      else $error("request without enabled pending bit");
   a_sync_clock: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      mode == uts_pkg::UTS_MODE_SHIFT && tx_st_q == uts_pkg::UTS_TX_IDLE
      && $past(tx_st_q) == uts_pkg::UTS_TX_IDLE |-> tx_pin_q)
      else $error("shift clock not idle high");
endmodule : uts_port
`default_nettype wire

// ===== common/uts_pkg.sv
// Purpose: constants and types shared by the three-mode serial port
// Assumes: 8-bit register port, one system clock
// Notes: offsets are byte addresses on the register port
package uts_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] UTS_PEND_OFS = 8'hf4;
   localparam logic [7:0] UTS_DATA_OFS = 8'hf5;
   localparam logic [7:0] UTS_CTRL_OFS = 8'hf6;
   localparam logic [7:0] UTS_DIVL_OFS = 8'hf8;
   localparam logic [7:0] UTS_DIVH_OFS = 8'hf9;
   // ==========================================================
   // field positions
   localparam int UTS_CTRL_MODE_LSB = 6;
   localparam int UTS_CTRL_MPC = 5;
   localparam int UTS_CTRL_RXEN = 4;
   localparam int UTS_CTRL_TB8 = 3;
   localparam int UTS_CTRL_RB8 = 2;
   localparam int UTS_CTRL_RIE = 1;
   localparam int UTS_CTRL_TIE = 0;
   localparam int UTS_PEND_PEN = 5;
   localparam int UTS_PEND_RPE = 3;
   localparam int UTS_PEND_RIP = 1;
   localparam int UTS_PEND_TIP = 0;
   // ==========================================================
   // reset values
   localparam logic [7:0] UTS_CTRL_RST = 8'h00;
   localparam logic [7:0] UTS_PEND_RST = 8'h00;
   localparam logic [7:0] UTS_BYTE_RST = 8'h00;
   localparam logic [15:0] UTS_DIV_RST = 16'h0000;
   // ==========================================================
   // timing: sixteen ticks per bit, eight bits per byte
   localparam int UTS_TICKS_PER_BIT = 16;
   localparam logic [3:0] UTS_TICK_LAST = 4'(UTS_TICKS_PER_BIT - 1);
   localparam logic [3:0] UTS_TICK_MID = 4'(UTS_TICKS_PER_BIT / 2 - 1);
   localparam logic [3:0] UTS_BIT_LAST8 = 4'h7;
   localparam logic [3:0] UTS_BIT_LAST9 = 4'h8;
   // ==========================================================
   // modes and states
   typedef enum logic [1:0] {
      UTS_MODE_SHIFT,
      UTS_MODE_8BIT,
      UTS_MODE_9BIT,
      UTS_MODE_9BIT_ALT
   } uts_mode_t;
   typedef enum logic [2:0] {
      UTS_TX_IDLE,
      UTS_TX_SYNC,
      UTS_TX_START,
      UTS_TX_DATA,
      UTS_TX_NINTH,
      UTS_TX_STOP
   } uts_tx_st_t;
   typedef enum logic [1:0] {
      UTS_RX_IDLE,
      UTS_RX_START,
      UTS_RX_DATA,
      UTS_RX_STOP
   } uts_rx_st_t;
endpackage : uts_pkg

// ===== logic/uts_tick.sv
// Purpose: rate tick, one pulse every divisor+1 system clocks
// Assumes: divisor may change at any time
// Notes: sixteen ticks make one serial bit
`timescale 1ns/1ps
`default_nettype none
module uts_tick #(
   parameter int DIV_W = 16
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic tick_o
);
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic tick_q;
   logic tick_d;
   // ==========================================================
   // divider
   always_comb begin
      tick_d = 1'b0;
      cnt_d = cnt_q + DIV_W'(1);
      // >= keeps a shrinking divisor from wrapping the full range
      if (cnt_q >= div_i) begin
         cnt_d = '0;
         tick_d = 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tick_o = tick_q;
   a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      tick_q && div_i == '0 && $stable(div_i) |=> tick_q)
      else $error("tick not every clock with divisor zero");
endmodule : uts_tick
`default_nettype wire

// ===== dv/uts_far_end.sv
// Purpose: far-end serial device on the port's receive and transmit pins
// Assumes: BITC system clocks per serial bit, set by the bench
// Notes: line idles high between frames, as a resting async line does
`timescale 1ns/1ps
`default_nettype none
module uts_far_end #(
   parameter int BITC = 16
) (
   input wire logic clk_sys_i,
   input wire logic tx_i,
   input wire logic pin_i,
   output logic rx_o
);
   initial rx_o = 1'b1;
   // ==========================================================
   // drive one frame: start, data lsb first, ninth if asked, stop
   task automatic send(input logic [7:0] d, input logic b9, input bit n9);
      logic [10:0] f;
      f = n9 ? {1'b1, b9, d, 1'b0} : {2'b11, d, 1'b0};
      for (int i = 0; i < (n9 ? 11 : 10); i++) begin
         rx_o <= f[i];
         repeat (BITC) @(posedge clk_sys_i);
      end
   endtask : send
   // ==========================================================
   // capture one frame mid-bit; ninth slot holds stop in 8-bit frames
   task automatic recv(input bit n9, output logic [8:0] v, output logic ok);
      for (int k = 0; k < 200 && tx_i !== 1'b0; k++) @(posedge clk_sys_i);
      repeat (BITC / 2) @(posedge clk_sys_i);
      ok = (tx_i === 1'b0);
      for (int i = 0; i < (n9 ? 9 : 8); i++) begin
         repeat (BITC) @(posedge clk_sys_i);
         v[i] = tx_i;
      end
      repeat (BITC) @(posedge clk_sys_i);
      ok = ok & (tx_i === 1'b1);
      if (!n9) v[8] = tx_i;
   endtask : recv
   // ==========================================================
   // shift mode: data taken on each rising shift clock
   task automatic shrecv(output logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         for (int k = 0; k < 80 && tx_i !== 1'b0; k++) @(posedge clk_sys_i);
         for (int k = 0; k < 80 && tx_i !== 1'b1; k++) @(posedge clk_sys_i);
         v[i] = pin_i;
      end
   endtask : shrecv
   // ==========================================================
   // shift mode receive: next bit placed after each falling shift clock
   task automatic shsend(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         rx_o <= d[i];
         for (int k = 0; k < 80 && tx_i !== 1'b0; k++) @(posedge clk_sys_i);
         for (int k = 0; k < 80 && tx_i !== 1'b1; k++) @(posedge clk_sys_i);
         for (int k = 0; k < 80 && tx_i !== 1'b0; k++) @(posedge clk_sys_i);
      end
      rx_o <= 1'b1;
   endtask : shsend
endmodule : uts_far_end
`default_nettype wire

// ===== dv/uts_port_bench.sv
// Purpose: self-checking bench for the three-mode serial port
// Assumes: divisor 1, so one bit is 32 system clocks
// Notes: one idle cycle between bus accesses keeps strobes single-driven
`timescale 1ns/1ps
`default_nettype none
module uts_port_bench;
   logic clk_sys_i, sys_rst_i, wr_en_i, rd_en_i, rx_i;
   logic [7:0] addr_i, wr_data_i, rd_data_o, d, ctrl, parity_enable;
   logic rx_o, rx_oe_o, tx_o, irq_o, far_rx, ok, b, rb;
   logic [8:0] v;
   logic [31:0] seed;
   logic [7:0] q[$];
   int bad_count, num_checks;
   assign rx_i = rx_oe_o ? rx_o : far_rx;
   uts_port #(.DIV_W(16)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o), .rx_i(rx_i), .rx_o(rx_o), .rx_oe_o(rx_oe_o),
      .tx_o(tx_o), .irq_o(irq_o));
   uts_far_end #(.BITC(32)) far (.clk_sys_i(clk_sys_i), .tx_i(tx_o),
      .pin_i(rx_i), .rx_o(far_rx));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys_i);
      addr_i <= a;
      wr_data_i <= x;
      wr_en_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_en_i <= 1'b0;
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_en_i <= 1'b0;
      #1 chk({1'b0, rd_data_o}, {1'b0, exp});
   endtask : rdchk
   task automatic final_report;
      if (bad_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   // ==========================================================
   // clock, watchdog, main sequence
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      bad_count++;
      final_report;
   end
   initial begin
      seed = 32'hc063;
      sys_rst_i = 1'b1;
      {wr_en_i, rd_en_i, addr_i, wr_data_i} = '0;
      repeat (12) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rdchk(uts_pkg::UTS_CTRL_OFS, 8'h00);
      rdchk(uts_pkg::UTS_PEND_OFS, 8'h00);
      wr(8'hf0, 8'hff);
      rdchk(8'hf0, 8'h00);
      wr(uts_pkg::UTS_DIVL_OFS, 8'h01);
      for (int c = 0; c < 3; c++) begin
         ctrl = (c == 0) ? 8'h51 : 8'h99;
         parity_enable = (c != 1) ? 8'h20 : 8'h00;
         wr(uts_pkg::UTS_PEND_OFS, parity_enable);
         wr(uts_pkg::UTS_CTRL_OFS, ctrl);
         d = seed[7:0];
         seed = xs(seed);
         wr(uts_pkg::UTS_DATA_OFS, d);
         far.recv(c != 0, v, ok);
         chk(9'(ok), 9'h001);
         chk(v, {(c == 2) ? ~^d : 1'b1, d});
         chk(9'(irq_o), 9'h001);
         rdchk(uts_pkg::UTS_PEND_OFS, parity_enable | 8'h01);
         wr(uts_pkg::UTS_PEND_OFS, parity_enable);
         for (int j = 0; j < 2; j++) begin
            d = seed[7:0];
            b = seed[9];
            seed = xs(seed);
            q.push_back(d);
            far.send(d, (c == 2) ? (^d ^ b) : b, c != 0);
         end
         rb = (c == 0) ? 1'b1 : (c == 1) ? b : 1'b0;
         rdchk(uts_pkg::UTS_PEND_OFS, parity_enable | 8'h02 | ((c == 2 && b) ? 8'h08 : 8'h00));
         rdchk(uts_pkg::UTS_DATA_OFS, q[$]);
         rdchk(uts_pkg::UTS_CTRL_OFS, {ctrl[7:3], rb, ctrl[1:0]});
         wr(uts_pkg::UTS_PEND_OFS, 8'h00);
      end
      fork
         far.send(8'h5a, 1'b1, 1'b0);
         begin
            repeat (100) @(posedge clk_sys_i);
            wr(uts_pkg::UTS_CTRL_OFS, 8'h41);
         end
      join
      rdchk(uts_pkg::UTS_PEND_OFS, 8'h00);
      rdchk(uts_pkg::UTS_DATA_OFS, q[$]);
      wr(uts_pkg::UTS_CTRL_OFS, 8'h00);
      d = seed[7:0];
      wr(uts_pkg::UTS_DATA_OFS, d);
      far.shrecv(v[7:0]);
      chk({1'b0, v[7:0]}, {1'b0, d});
      repeat (40) @(posedge clk_sys_i);
      rdchk(uts_pkg::UTS_PEND_OFS, 8'h01);
      wr(uts_pkg::UTS_PEND_OFS, 8'h00);
      seed = xs(seed);
      d = seed[7:0];
      wr(uts_pkg::UTS_CTRL_OFS, 8'h12);
      far.shsend(d);
      chk(9'(irq_o), 9'h001);
      rdchk(uts_pkg::UTS_PEND_OFS, 8'h02);
      // a restarted receive would refill the buffer with idle ones
      repeat (300) @(posedge clk_sys_i);
      rdchk(uts_pkg::UTS_DATA_OFS, d);
      final_report;
   end
endmodule : uts_port_bench
`default_nettype wire
